// ### hdl/adc_readout_map.svh
// constants for the converter control and result readout block
//
// Overview of operation
// - format select high straight binary, low two's complement
// - parallel reads keep result; serial pulses shift it
// - parallel port driven only for read high, select low
// - half select low upper byte, high lower
// - half select may toggle within one cycle
// - result register undefined before first conversion
// - result updated first, then busy rises
// - previous result held at least 12 us
// - internal clock mode: start also shifts previous result
// - external clock mode: conversion still internally paced
// - external mode: select falling while idle outputs result
// - external mode: shift previous result during conversion
// - both inputs low at busy rise restarts conversion
// - commands ignored while busy is low
// - two's complement codes 7fff, 0000, ffff, 8000
// - straight binary codes ffff, 8000, 7fff, 0000
// - result valid 19 to 20 us after start
// - busy falls within 85 ns of start
// - select and read/convert OR'd, level sensitive
// - internal mode: 16 pulses, most significant bit first
// - serial clock pin output when internal, input when external
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

// ****************
// timing
// ****************
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 19000
`define PREV_VALID_NS 12000
`define START_DLY_NS 1400
`define SCLK_PERIOD_NS 1100
`define CONV_CYC 11'((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PREV_CYC 11'(`PREV_VALID_NS / `CLK_PERIOD_NS)
`define START_DLY_CYC 8'((`START_DLY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYC 8'((`SCLK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************
// data layout
// ****************
`define RESULT_W 16
`define SER_BITS 5'h10
`define SIGN_FLIP 16'h8000
`define RESULT_RST 16'h0000
`define FIFO_DEPTH 8

`endif

// ### hdl/adc_readout_pkg.sv
// types shared by the converter readout block
package adc_readout_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_UPD = 2'h3
  } conv_state_t;
  typedef logic [15:0] sample_t;
endpackage : adc_readout_pkg

// ### hdl/sample_fifo.sv
// small fifo with registered read data between conversion core and result register
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] rd_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign rd_nxt = pop ? ptr_inc(rd_r) : rd_r;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= ptr_inc(wr_r);
      end
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
      out_valid <= (cnt_nxt != '0);
    end
  end

  // a word written into an empty head slot bypasses the memory read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
    end else if (push && cnt_nxt == (AW+1)'(1)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem_r[rd_nxt];
    end
  end
endmodule : sample_fifo

// ### hdl/adc_result_readout.sv
// conversion control, parallel and serial result readout of a sampling converter
`timescale 1ns/1ps
`include "adc_readout_map.svh"
module adc_result_readout import adc_readout_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic read_convert,
  input wire logic half_select,
  input wire logic code_format_select,
  input wire logic clock_source_select,
  input wire logic serial_clock_in,
  input wire logic [15:0] raw_data,
  input wire logic raw_valid,
  output logic raw_ready,
  output logic hold_strobe,
  output logic busy_n,
  output logic [7:0] parallel_out,
  output logic parallel_oe,
  output logic serial_out,
  output logic serial_clock_out,
  output logic serial_clock_oe
);

  // ****************
  // pin synchronisers
  // ****************
  // bit order: 0 cs_n, 1 read_convert, 2 half, 3 format, 4 clock source, 5 serial clock
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  logic sclk_del_r;

  // clock source resets to external so the shared clock pin stays undriven out of reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_r <= 6'h13;
      pin_sync_r <= 6'h13;
      sclk_del_r <= 1'b0;
    end else begin
      pin_meta_r <= {serial_clock_in, clock_source_select, code_format_select,
                     half_select, read_convert, cs_n};
      pin_sync_r <= pin_meta_r;
      sclk_del_r <= pin_sync_r[5];
    end
  end

  logic cs_s;
  logic rc_s;
  logic half_s;
  logic fmt_s;
  logic ext_s;
  logic sclk_s;

  assign cs_s = pin_sync_r[0];
  assign rc_s = pin_sync_r[1];
  assign half_s = pin_sync_r[2];
  assign fmt_s = pin_sync_r[3];
  assign ext_s = pin_sync_r[4];
  assign sclk_s = pin_sync_r[5];

  // ****************
  // output code format
  // ****************
  // the core delivers offset binary; two's complement only flips the top bit
  function automatic sample_t fmt_word(input sample_t raw, input logic straight);
    fmt_word = straight ? raw : (raw ^ `SIGN_FLIP);
  endfunction : fmt_word

  // ****************
  // conversion control
  // ****************
  conv_state_t state_r;
  logic [10:0] conv_cnt_r;
  logic busy_n_r;
  logic start;
  logic conv_done;
  logic pop;
  logic fifo_valid;
  sample_t fifo_data;
  logic ser_act_r;

  // level sensitive: whichever input goes low last starts it, and a pair
  // still low when busy rises restarts at once without acquisition
  assign start = busy_n_r & ~(cs_s | rc_s) & (state_r == ST_IDLE);
  assign conv_done = (conv_cnt_r >= `CONV_CYC);
  // busy stays low until serial transmission in internal mode is also done
  assign pop = (state_r == ST_CONV) & conv_done & fifo_valid & ~ser_act_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (pop) begin
            state_r <= ST_UPD;
          end
        end
        ST_UPD: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // paced by the reference clock whatever the serial clock source
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_cnt_r <= '0;
    end else if (start) begin
      conv_cnt_r <= '0;
    end else if (state_r == ST_CONV && !conv_done) begin
      conv_cnt_r <= conv_cnt_r + 11'h001;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_n_r <= 1'b1;
    end else if (start) begin
      busy_n_r <= 1'b0;
    end else if (state_r == ST_UPD) begin
      busy_n_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_strobe <= 1'b0;
    end else begin
      hold_strobe <= start;
    end
  end

  assign busy_n = busy_n_r;

  // ****************
  // result buffer
  // ****************
  // the core may run ahead; a full buffer stalls it through raw_ready
  sample_fifo #(
    .WIDTH(`RESULT_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(sys_rst),
    .in_valid(raw_valid),
    .in_data(raw_data),
    .in_ready(raw_ready),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // ****************
  // internal serial clock
  // ****************
  logic [7:0] ser_half_r;
  logic [4:0] ser_bits_r;
  logic sclk_r;
  logic int_shift;
  logic ext_shift;

  assign int_shift = ser_act_r & (ser_half_r == 8'h00) & sclk_r;
  // external clock shifts on its falling edge, only while reading is enabled
  assign ext_shift = ext_s & ~cs_s & rc_s & ~sclk_s & sclk_del_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_act_r <= 1'b0;
      ser_half_r <= '0;
      ser_bits_r <= '0;
      sclk_r <= 1'b0;
    end else if (start && !ext_s) begin
      ser_act_r <= 1'b1;
      ser_half_r <= `START_DLY_CYC - 8'h01;
      ser_bits_r <= `SER_BITS;
      sclk_r <= 1'b0;
    end else if (ser_act_r) begin
      if (ser_half_r == 8'h00) begin
        ser_half_r <= `SCLK_HALF_CYC - 8'h01;
        sclk_r <= ~sclk_r;
        if (sclk_r) begin
          ser_bits_r <= ser_bits_r - 5'h01;
          if (ser_bits_r == 5'h01) begin
            ser_act_r <= 1'b0;
          end
        end
      end else begin
        ser_half_r <= ser_half_r - 8'h01;
      end
    end
  end

  // ****************
  // result register
  // ****************
  // one register feeds both ports, so serial reading destroys the parallel view;
  // reset value is arbitrary, nothing valid exists before the first conversion
  sample_t result_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= `RESULT_RST;
    end else if (pop) begin
      result_r <= fmt_word(fifo_data, fmt_s);
    end else if (int_shift || ext_shift) begin
      result_r <= {result_r[14:0], 1'b0};
    end
  end

  // ****************
  // output pins
  // ****************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parallel_out <= '0;
      parallel_oe <= 1'b0;
      serial_out <= 1'b0;
      serial_clock_out <= 1'b0;
      serial_clock_oe <= 1'b0;
    end else begin
      parallel_oe <= rc_s & ~cs_s;
      parallel_out <= half_s ? result_r[7:0] : result_r[15:8];
      serial_out <= result_r[15];
      serial_clock_out <= sclk_r;
      serial_clock_oe <= ~ext_s;
    end
  end

  // ****************
  // checks
  // ****************
  logic [4:0] pulse_cnt_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_cnt_r <= '0;
    end else if (start) begin
      pulse_cnt_r <= '0;
    end else if (int_shift) begin
      pulse_cnt_r <= pulse_cnt_r + 5'h01;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  busy_fall_a: assert property (start |=> !busy_n_r ##1 !busy_n)
    else $error("busy did not fall after a start");
  conv_length_a: assert property ($rose(busy_n_r) |-> conv_cnt_r == `CONV_CYC)
    else $error("conversion ended at the wrong cycle count");
  ignore_cmd_a: assert property (!busy_n_r && state_r == ST_CONV |=> state_r != ST_IDLE)
    else $error("conversion abandoned while busy");
  update_first_a: assert property ($rose(busy_n_r) |-> $past(pop, 2) && $past(state_r) == ST_UPD)
    else $error("busy rose without a prior result update");
  hold_prev_a: assert property (pop |-> conv_cnt_r >= `PREV_CYC)
    else $error("previous result replaced too early");
  code_format_a: assert property (pop |=> result_r == ($past(fmt_s) ? $past(fifo_data)
                                   : ($past(fifo_data) ^ `SIGN_FLIP)))
    else $error("result loaded in the wrong format");
  hiz_gate_a: assert property (cs_s || !rc_s |=> !parallel_oe)
    else $error("parallel port driven outside a read");
  half_pick_a: assert property (!pop && !ext_shift && !int_shift ##1 half_s |=>
                                parallel_out == $past(result_r[7:0]))
    else $error("lower half not presented");
  ext_shift_a: assert property (ext_shift && !pop |=>
                                result_r == {$past(result_r[14:0]), 1'b0})
    else $error("external clock pulse did not shift the result");
  pulse_count_a: assert property ($fell(ser_act_r) |-> pulse_cnt_r == `SER_BITS)
    else $error("internal serial burst did not give sixteen pulses");
  clk_dir_a: assert property (ext_s |=> !serial_clock_oe)
    else $error("serial clock driven in external mode");
  int_clk_a: assert property (!ext_s |=> serial_clock_oe)
    else $error("serial clock not driven in internal mode");
  drive_on_a: assert property (rc_s && !cs_s |=> parallel_oe)
    else $error("parallel port not driven during a read");
  upper_pick_a: assert property (!pop && !ext_shift && !int_shift ##1 !half_s |=>
                                 parallel_out == $past(result_r[15:8]))
    else $error("upper half not presented");
  busy_hold_a: assert property (!busy_n_r && state_r != ST_UPD |=> !busy_n_r)
    else $error("busy rose before the result was updated");
  // a pair still low when busy rises starts again with no acquisition
  restart_a: assert property ($rose(busy_n_r) && !cs_s && !rc_s |=> !busy_n_r)
    else $error("no immediate restart with both inputs low");
  strobe_pulse_a: assert property (hold_strobe |=> !hold_strobe)
    else $error("hold strobe longer than one cycle");
  // serial_out trails the register by a cycle so it is steady at each rise
  msb_out_a: assert property (serial_out == $past(result_r[15]))
    else $error("serial output does not show the top result bit");
  burst_stop_a: assert property (!ser_act_r |=> !$rose(sclk_r))
    else $error("internal serial clock ran outside a burst");

endmodule : adc_result_readout

// ### testbench/host_serial_model.sv
// host side serial reader: external clock bursts and bit capture
`timescale 1ns/1ps
module host_serial_model (
  input wire logic drive_clk,
  input wire logic sclk_wire,
  input wire logic serial_out,
  input wire logic frame_go,
  output logic host_clk,
  output logic [15:0] rx_word,
  output logic [4:0] rx_count
);
  // ******
  // external clock
  // ******
  // clock rests low between frames so no stray fall shifts the result
  initial host_clk = 1'b0;
  always @(posedge frame_go) begin
    if (drive_clk) begin
      repeat (16) begin
        #80 host_clk = 1'b1;
        #80 host_clk = 1'b0;
      end
    end
  end
  // bits taken on the rising clock, where the device holds them stable
  always @(posedge sclk_wire or posedge frame_go) begin
    if (frame_go) begin
      rx_word <= 16'h0000;
      rx_count <= 5'h00;
    end else begin
      rx_word <= {rx_word[14:0], serial_out};
      rx_count <= rx_count + 5'h01;
    end
  end
endmodule : host_serial_model

// ### testbench/adc_result_readout_tb_top.sv
// self-checking bench for the converter control and readout block
`timescale 1ns/1ps
module adc_result_readout_tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst, cs_n, read_convert, half_select, code_format_select;
  logic clock_source_select, raw_valid, frame_go, raw_ready, hold_strobe, busy_n;
  logic parallel_oe, serial_out, serial_clock_out, serial_clock_oe, host_clk, sclk_wire;
  logic [15:0] raw_data, last_res, rx_word;
  logic [7:0] parallel_out;
  logic [4:0] rx_count;
  int errors = 0;
  int n_tests = 0;
  int hs_count = 0;
  // one shared serial clock pin: device drives it only while enabled
  assign sclk_wire = serial_clock_oe ? serial_clock_out : host_clk;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (hold_strobe === 1'b1) hs_count++;
  adc_result_readout adc_result_readout_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cs_n(cs_n), .read_convert(read_convert), .half_select(half_select),
    .code_format_select(code_format_select), .clock_source_select(clock_source_select),
    .serial_clock_in(sclk_wire), .raw_data(raw_data), .raw_valid(raw_valid),
    .raw_ready(raw_ready), .hold_strobe(hold_strobe), .busy_n(busy_n),
    .parallel_out(parallel_out), .parallel_oe(parallel_oe), .serial_out(serial_out),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe));
  host_serial_model host_serial_model_inst (.drive_clk(clock_source_select),
    .sclk_wire(sclk_wire), .serial_out(serial_out), .frame_go(frame_go),
    .host_clk(host_clk), .rx_word(rx_word), .rx_count(rx_count));
  // ******
  // helpers
  // ******
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_busy(input logic lvl, input int lim, inout int n);
    while (busy_n !== lvl && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_busy
  task automatic push(input logic [15:0] w);
    @(negedge ref_clk);
    raw_data = w;
    raw_valid = 1'b1;
    @(negedge ref_clk);
    raw_valid = 1'b0;
  endtask : push
  task automatic pulse_frame();
    frame_go = 1'b1;
    @(negedge ref_clk);
    frame_go = 1'b0;
  endtask : pulse_frame
  task automatic read_par(input logic [15:0] exp);
    @(negedge ref_clk);
    cs_n = 1'b0;
    read_convert = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(parallel_oe, 1'b1);
    check(parallel_out, exp[15:8]);
    half_select = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(parallel_out, exp[7:0]);
    cs_n = 1'b1;
    half_select = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(parallel_oe, 1'b0);
  endtask : read_par
  // start, watch the previous result during conversion, then the new one
  task automatic conv(input logic [15:0] exp, input logic by_cs, input logic chk);
    int n = 0;
    @(negedge ref_clk);
    read_convert = 1'b0;
    if (by_cs) @(negedge ref_clk);
    cs_n = 1'b0;
    wait_busy(1'b0, 20, n);
    check(n <= 8, 1'b1);
    read_convert = 1'b1;
    repeat (1100) @(negedge ref_clk);
    n += 1100;
    if (chk) check(parallel_out, last_res[15:8]);
    wait_busy(1'b1, 2100, n);
    check(n <= 2000, 1'b1);
    check(parallel_out, exp[15:8]);
    cs_n = 1'b1;
    last_res = exp;
  endtask : conv
  // ******
  // scenarios
  // ******
  task automatic fill_and_codes();
    logic [15:0] codes [4] = '{16'hffff, 16'h8000, 16'h7fff, 16'h0000};
    logic [15:0] e;
    @(negedge ref_clk);
    raw_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      raw_data = codes[i % 4];
      @(negedge ref_clk);
    end
    raw_data = 16'h5555;
    repeat (2) @(negedge ref_clk);
    check(raw_ready, 1'b0);
    raw_valid = 1'b0;
    for (int i = 0; i < 8; i++) begin
      code_format_select = (i < 4);
      e = (i < 4) ? codes[i % 4] : codes[i % 4] ^ 16'h8000;
      conv(e, i[0], i > 0);
      check(raw_ready, 1'b1);
      read_par(e);
    end
  endtask : fill_and_codes
  task automatic serial_paths();
    @(negedge ref_clk);
    clock_source_select = 1'b0;
    code_format_select = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(serial_clock_oe, 1'b1);
    push(16'h1234);
    pulse_frame();
    conv(16'h1234, 1'b1, 1'b0);
    check(rx_word, 16'h8000);
    check(rx_count, 5'h10);
    clock_source_select = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(serial_clock_oe, 1'b0);
    read_par(16'h1234);
    cs_n = 1'b0;
    pulse_frame();
    repeat (270) @(negedge ref_clk);
    check(rx_word, 16'h1234);
    cs_n = 1'b1;
    read_par(16'h0000);
  endtask : serial_paths
  task automatic restart();
    int n = 0;
    int hs0;
    push(16'h0001);
    push(16'h0002);
    @(negedge ref_clk);
    cs_n = 1'b0;
    read_convert = 1'b0;
    wait_busy(1'b0, 20, n);
    read_convert = 1'b1;
    @(negedge ref_clk);
    // the strobe of this start has been counted by now
    hs0 = hs_count;
    read_convert = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(16'(hs_count), 16'(hs0));
    n = 0;
    wait_busy(1'b1, 2100, n);
    n = 0;
    wait_busy(1'b0, 10, n);
    check(n <= 5, 1'b1);
    read_convert = 1'b1;
    cs_n = 1'b1;
    n = 0;
    wait_busy(1'b1, 2100, n);
    read_par(16'h0002);
  endtask : restart
  task automatic tally_and_finish();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial begin
    cs_n = 1'b1;
    read_convert = 1'b1;
    half_select = 1'b0;
    code_format_select = 1'b1;
    clock_source_select = 1'b1;
    raw_data = 16'h0000;
    raw_valid = 1'b0;
    frame_go = 1'b0;
    last_res = 16'h0000;
    sys_rst = 1'b1;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    fill_and_codes();
    serial_paths();
    restart();
    tally_and_finish();
  end
endmodule : adc_result_readout_tb_top
